// [xtal_ref_ctrl.sv]
// crystal enable, load-capacitance trim selection, reference doublers,
// 3-bit reference dividers and per-PLL smart reference selection;
// assumes config bits are static register outputs on i_clk, and that
// the trim level pin arrives as a 3-bit code from an eight-band quantizer
`timescale 1ns/100ps

module xtal_ref_ctrl #(
  parameter int unsigned DIV_W = xtal_ref_pkg::REF_DIV_W
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  input  wire xtal_ref_pkg::xtal_cfg_s  i_cfg,
  input  wire logic [xtal_ref_pkg::TABLE_REGS-1:0]
                    [xtal_ref_pkg::TRIM_REG_W-1:0] i_level_trim_table,
  input  wire logic                     i_trim_override_pin,
  input  wire logic [xtal_ref_pkg::LEVEL_W-1:0] i_trim_level_pin,
  input  wire logic                     i_primary_ref,
  input  wire logic                     i_secondary_reference_input,
  input  wire xtal_ref_pkg::ref_sel_s [xtal_ref_pkg::PLL_COUNT-1:0] i_ref_sel,
  input  wire logic                     i_primary_lost,
  input  wire logic                     i_secondary_lost,
  output logic                          o_xtal_osc_en,
  output logic [xtal_ref_pkg::TRIM_CODE_W-1:0] o_trim_code,
  output logic                          o_secondary_ref_pulse,
  output logic [xtal_ref_pkg::PLL_COUNT-1:0] o_pll_ref_pulse,
  output logic [xtal_ref_pkg::PLL_COUNT-1:0] o_pll_on_secondary
);

  // ==========================================================
  // pin synchronisers
  // every pin passes two flops; only the second stage is read
  logic                                 ovr_s1_ff;
  logic                                 ovr_s2_ff;
  logic [xtal_ref_pkg::LEVEL_W-1:0]     lvl_s1_ff;
  logic [xtal_ref_pkg::LEVEL_W-1:0]     lvl_s2_ff;
  logic [xtal_ref_pkg::LEVEL_W-1:0]     lvl_hold_ff;
  logic [1:0]                           pri_s_ff;
  logic [1:0]                           sec_s_ff;
  logic                                 pri_last_ff;
  logic                                 sec_last_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ovr_s1_ff   <= 1'b0;
      ovr_s2_ff   <= 1'b0;
      lvl_s1_ff   <= '0;
      lvl_s2_ff   <= '0;
      pri_s_ff    <= 2'h0;
      sec_s_ff    <= 2'h0;
      pri_last_ff <= 1'b0;
      sec_last_ff <= 1'b0;
    end else begin
      ovr_s1_ff   <= i_trim_override_pin;
      ovr_s2_ff   <= ovr_s1_ff;
      lvl_s1_ff   <= i_trim_level_pin;
      lvl_s2_ff   <= lvl_s1_ff;
      pri_s_ff    <= {pri_s_ff[0], i_primary_ref};
      sec_s_ff    <= {sec_s_ff[0], i_secondary_reference_input};
      pri_last_ff <= pri_s_ff[1];
      sec_last_ff <= sec_s_ff[1];
    end
  end

  // the quantizer bits may skew while the voltage crosses a band edge,
  // so a new level is taken only after two equal synchronised samples
  logic lvl_stable;
  assign lvl_stable = (lvl_s2_ff == lvl_hold_ff);

  logic [xtal_ref_pkg::LEVEL_W-1:0] lvl_used_ff;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lvl_hold_ff <= '0;
      lvl_used_ff <= '0;
    end else begin
      lvl_hold_ff <= lvl_s2_ff;
      if (lvl_stable) begin
        lvl_used_ff <= lvl_hold_ff;
      end
    end
  end

  // ==========================================================
  // crystal oscillator enable
  logic nxt_xtal_osc_en;
  assign nxt_xtal_osc_en =
    ({i_cfg.secondary_type_sel_hi, i_cfg.secondary_type_sel_lo}
      == xtal_ref_pkg::SEC_TYPE_XTAL) && i_cfg.secondary_bias_en;

  // ==========================================================
  // trim code selection
  // each table level owns two registers, first one as the high byte
  xtal_ref_pkg::trim_src_e         trim_src;
  logic [xtal_ref_pkg::TRIM_CODE_W-1:0] level_code;
  logic [xtal_ref_pkg::TRIM_CODE_W-1:0] alt_code;
  logic [xtal_ref_pkg::TRIM_CODE_W-1:0] fixed_code;
  logic [xtal_ref_pkg::TRIM_CODE_W-1:0] nxt_trim_code;
  logic [3:0]                           lvl_idx;

  assign trim_src = xtal_ref_pkg::trim_src_e'(
    {i_cfg.trim_source_sel_hi, i_cfg.trim_source_sel_lo});
  assign lvl_idx  = {lvl_used_ff, 1'b0};
  assign level_code = {i_level_trim_table[lvl_idx],
                       i_level_trim_table[lvl_idx + 4'h1]};
  // the alternate pair shares storage with table level three
  assign alt_code = {i_level_trim_table[xtal_ref_pkg::ALT_TABLE_IDX],
                     i_level_trim_table[xtal_ref_pkg::ALT_TABLE_IDX + 1]};
  // code step is one capacitor unit of the trim array
  assign fixed_code = {i_cfg.fixed_trim_code_a,
                       i_cfg.fixed_trim_code_b};

  // select 1,1 is left undefined; it is treated as fixed pair only
  always_comb begin
    unique case (trim_src)
      xtal_ref_pkg::SRC_PIN_ONLY:
        nxt_trim_code = level_code;
      xtal_ref_pkg::SRC_PIN_OR_ALT:
        nxt_trim_code = ovr_s2_ff ? alt_code : level_code;
      xtal_ref_pkg::SRC_PIN_OR_FIXED:
        nxt_trim_code = ovr_s2_ff ? fixed_code : level_code;
      xtal_ref_pkg::SRC_FIXED:
        nxt_trim_code = fixed_code;
    endcase
  end

  // reload only on change so the trim array never sees needless strobes
  logic trim_change;
  assign trim_change = (nxt_trim_code != o_trim_code);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_trim_code   <= xtal_ref_pkg::TRIM_CODE_RST;
      o_xtal_osc_en <= 1'b0;
    end else begin
      o_xtal_osc_en <= nxt_xtal_osc_en;
      if (trim_change) begin
        o_trim_code <= nxt_trim_code;
      end
    end
  end

  // ==========================================================
  // doublers: a plain reference gives one pulse per rising edge,
  // a doubled one a pulse on both edges
  logic pri_rise;
  logic pri_fall;
  logic sec_rise;
  logic sec_fall;
  logic pri_evt;
  logic sec_evt;
  assign pri_rise = pri_s_ff[1] & ~pri_last_ff;
  assign pri_fall = ~pri_s_ff[1] & pri_last_ff;
  assign sec_rise = sec_s_ff[1] & ~sec_last_ff;
  assign sec_fall = ~sec_s_ff[1] & sec_last_ff;
  assign pri_evt  = pri_rise | (i_cfg.primary_doubler_en & pri_fall);
  assign sec_evt  = sec_rise | (i_cfg.secondary_doubler_en & sec_fall);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_secondary_ref_pulse <= 1'b0;
    end else begin
      o_secondary_ref_pulse <= sec_evt;
    end
  end

  // ==========================================================
  // per-PLL reference divider and smart selection
  logic [xtal_ref_pkg::PLL_COUNT-1:0][DIV_W-1:0] div_val;
  assign div_val[0] = DIV_W'(i_cfg.pll1_ref_divide);
  assign div_val[1] = DIV_W'(i_cfg.pll2_ref_divide);

  genvar g;
  generate
    for (g = 0; g < xtal_ref_pkg::PLL_COUNT; g++) begin : g_pll
      logic [DIV_W-1:0] cnt_ff;
      logic [DIV_W-1:0] last_cnt;
      logic             div_hit;
      logic             nxt_on_sec;
      // divide value 0 behaves as the full count of the counter
      assign last_cnt = div_val[g] - DIV_W'(1);
      assign div_hit  = pri_evt && (cnt_ff == last_cnt);

      // in auto mode: loss of primary moves to secondary, its return
      // moves back; with both lost the selection waits on secondary
      assign nxt_on_sec = i_ref_sel[g].auto_mode ? i_primary_lost
                        : i_ref_sel[g].manual_secondary;

      // counter never restarts on a divide change, it runs on
      always_ff @(posedge i_clk) begin
        if (i_rst) begin
          cnt_ff                <= DIV_W'(xtal_ref_pkg::REF_CNT_RST);
          o_pll_ref_pulse[g]    <= 1'b0;
          o_pll_on_secondary[g] <= 1'b0;
        end else begin
          if (pri_evt) begin
            cnt_ff <= div_hit ? '0 : cnt_ff + DIV_W'(1);
          end
          o_pll_on_secondary[g] <= nxt_on_sec;
          o_pll_ref_pulse[g]    <= o_pll_on_secondary[g] ? sec_evt
                                                         : div_hit;
        end
      end
    end
  endgenerate

endmodule // xtal_ref_ctrl

// [xtal_ref_pkg.sv]
// constants and carriers for the crystal trim and reference conditioning
// block; assumes a single 50 MHz system clock and no register bus
package xtal_ref_pkg;

  // ==========================================================
  // trim range and step sizes (capacitance in femtofarads)
  localparam int unsigned TRIM_CAP_MIN_FF  = 14000;
  localparam int unsigned TRIM_CAP_MAX_FF  = 24000;
  localparam int unsigned TRIM_STEP_FF     = 14;
  localparam int unsigned OFFSET_LSB_FF    = 20;
  // trim pin full scale and band width, millivolts
  localparam int unsigned LEVEL_FULL_MV    = 1800;
  localparam int unsigned LEVEL_BAND_MV    = 200;
  localparam int unsigned LEVEL_COUNT      = 8;

  // ==========================================================
  // widths, table layout and reset values
  localparam int unsigned TRIM_REG_W       = 8;
  localparam int unsigned TRIM_CODE_W      = 2 * TRIM_REG_W;
  localparam int unsigned LEVEL_W          = 3;
  localparam int unsigned TABLE_REGS       = 16;
  localparam int unsigned ALT_TABLE_IDX    = 6;
  localparam int unsigned REF_DIV_W        = 3;
  localparam int unsigned PLL_COUNT        = 2;
  localparam logic [TRIM_CODE_W-1:0] TRIM_CODE_RST = 16'h0000;
  localparam logic [REF_DIV_W-1:0]   REF_CNT_RST   = 3'h0;

  // secondary input type that selects the crystal oscillator
  localparam logic [1:0] SEC_TYPE_XTAL     = 2'h2;

  // ==========================================================
  // trim source select, {hi, lo}
  typedef enum logic [1:0] {
    SRC_PIN_OR_ALT   = 2'h0,
    SRC_PIN_ONLY     = 2'h1,
    SRC_PIN_OR_FIXED = 2'h2,
    SRC_FIXED        = 2'h3
  } trim_src_e;

  // configuration bits written by host software
  typedef struct packed {
    logic                  secondary_type_sel_hi;
    logic                  secondary_type_sel_lo;
    logic                  secondary_bias_en;
    logic                  trim_source_sel_hi;
    logic                  trim_source_sel_lo;
    logic [TRIM_REG_W-1:0] fixed_trim_code_a;
    logic [TRIM_REG_W-1:0] fixed_trim_code_b;
    logic                  primary_doubler_en;
    logic                  secondary_doubler_en;
    logic [REF_DIV_W-1:0]  pll1_ref_divide;
    logic [REF_DIV_W-1:0]  pll2_ref_divide;
  } xtal_cfg_s;

  // per-PLL reference selection controls
  typedef struct packed {
    logic auto_mode;
    logic manual_secondary;
  } ref_sel_s;

endpackage

// [xtal_ref_ctrl_props.sv]
// assertion checker for xtal_ref_ctrl, bound onto its ports
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/100ps
module xtal_ref_ctrl_props #(
  parameter int unsigned DIV_W = xtal_ref_pkg::REF_DIV_W
) (
  input wire logic                         i_clk,
  input wire logic                         i_rst,
  input wire xtal_ref_pkg::xtal_cfg_s      i_cfg,
  input wire logic [15:0][7:0]             i_level_trim_table,
  input wire logic                         i_trim_override_pin,
  input wire logic [2:0]                   i_trim_level_pin,
  input wire logic                         i_secondary_reference_input,
  input wire xtal_ref_pkg::ref_sel_s [1:0] i_ref_sel,
  input wire logic                         i_primary_lost,
  input wire logic                         o_xtal_osc_en,
  input wire logic [15:0]                  o_trim_code,
  input wire logic                         o_secondary_ref_pulse,
  input wire logic [1:0]                   o_pll_ref_pulse,
  input wire logic [1:0]                   o_pll_on_secondary
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ======
  // helpers: quiet-input counter outlasts the 5-cycle level pin path
  logic [2:0]  calm_ff;
  // five quiet edges: enough for the level pin path, yet short enough
  // for the checks to fire between trim steps eight cycles apart
  wire         calm = (calm_ff == 3'h5);
  wire [1:0]   src = {i_cfg.trim_source_sel_hi, i_cfg.trim_source_sel_lo};
  wire [15:0]  lvl_code = {i_level_trim_table[{i_trim_level_pin, 1'b0}],
                           i_level_trim_table[{i_trim_level_pin, 1'b1}]};
  wire [15:0]  fix_code = {i_cfg.fixed_trim_code_a, i_cfg.fixed_trim_code_b};
  wire [1:0]   want_sec;
  assign want_sec[0] = i_ref_sel[0].auto_mode ? i_primary_lost
                                              : i_ref_sel[0].manual_secondary;
  assign want_sec[1] = i_ref_sel[1].auto_mode ? i_primary_lost
                                              : i_ref_sel[1].manual_secondary;
  always_ff @(posedge i_clk) begin
    if (i_rst || !($stable(i_cfg) && $stable(i_level_trim_table) &&
        $stable(i_trim_level_pin) && $stable(i_trim_override_pin)))
      calm_ff <= 3'h0;
    else if (!calm)
      calm_ff <= calm_ff + 3'h1;
  end
  sequence still;
    $stable(i_cfg) && $stable(i_level_trim_table) &&
    $stable(i_trim_level_pin) && $stable(i_trim_override_pin);
  endsequence
  // ======
  // assertions
  chk_osc_enable:
    assert property (!$past(i_rst) |-> o_xtal_osc_en == $past(
      i_cfg.secondary_type_sel_hi && !i_cfg.secondary_type_sel_lo &&
      i_cfg.secondary_bias_en)) else $error("crystal enable wrong");
  chk_trim_fixed:
    assert property (still ##0 calm && (src == 2'h3 || src == 2'h2 &&
      i_trim_override_pin) |-> o_trim_code == fix_code)
      else $error("fixed trim code wrong");
  chk_trim_alt:
    assert property (still ##0 calm && src == 2'h0 && i_trim_override_pin
      |-> o_trim_code == {i_level_trim_table[6], i_level_trim_table[7]})
      else $error("alternate trim code wrong");
  chk_trim_level:
    assert property (still ##0 calm && (src == 2'h1 || !src[0] &&
      !i_trim_override_pin) |-> o_trim_code == lvl_code)
      else $error("level trim code wrong");
  chk_trim_hold:
    assert property (still ##0 calm |=> $stable(o_trim_code))
      else $error("trim code moved with quiet inputs");
  chk_sel_follow:
    assert property (!$past(i_rst) |-> o_pll_on_secondary == $past(want_sec))
      else $error("reference selection wrong");
  chk_sec_pulse:
    assert property ($rose(i_secondary_reference_input) ||
      i_cfg.secondary_doubler_en && $fell(i_secondary_reference_input)
      |-> ##[3:6] o_secondary_ref_pulse) else $error("secondary pulse lost");
  chk_pulse_single:
    assert property (o_secondary_ref_pulse |=> !o_secondary_ref_pulse)
      else $error("secondary pulse too long");
  cov_level: cover property (calm && src == 2'h1);
  cov_alt: cover property (calm && src == 2'h0 && i_trim_override_pin);
  cov_pll2: cover property (o_pll_ref_pulse[1] && o_pll_on_secondary[1]);
endmodule // xtal_ref_ctrl_props

bind xtal_ref_ctrl xtal_ref_ctrl_props #(.DIV_W(DIV_W)) xtal_ref_ctrl_props_i (
  .i_clk(i_clk), .i_rst(i_rst), .i_cfg(i_cfg),
  .i_level_trim_table(i_level_trim_table),
  .i_trim_override_pin(i_trim_override_pin),
  .i_trim_level_pin(i_trim_level_pin),
  .i_secondary_reference_input(i_secondary_reference_input),
  .i_ref_sel(i_ref_sel), .i_primary_lost(i_primary_lost),
  .o_xtal_osc_en(o_xtal_osc_en), .o_trim_code(o_trim_code),
  .o_secondary_ref_pulse(o_secondary_ref_pulse),
  .o_pll_ref_pulse(o_pll_ref_pulse), .o_pll_on_secondary(o_pll_on_secondary));

// [xtal_host_model.sv]
// host software model owning the configuration bits
// assumes its tasks are called from the bench at a rising edge
`timescale 1ns/100ps
module xtal_host_model (
  input  wire logic               i_clk,
  output xtal_ref_pkg::xtal_cfg_s o_cfg
);
  initial o_cfg = '0;
  // one register write lands per edge, like a bus write
  task automatic put(input xtal_ref_pkg::xtal_cfg_s c);
    @(posedge i_clk) o_cfg <= c;
  endtask
  // source first, then first code before second; extra edge lets it land
  task automatic fixed_pair(input logic [7:0] a, input logic [7:0] b);
    @(posedge i_clk) o_cfg.trim_source_sel_hi <= 1'b1;
    o_cfg.trim_source_sel_lo <= 1'b0;
    @(posedge i_clk) o_cfg.fixed_trim_code_a <= a;
    @(posedge i_clk) o_cfg.fixed_trim_code_b <= b;
    @(posedge i_clk);
  endtask
endmodule // xtal_host_model

// [xtal_ref_ctrl_bench.sv]
// self-checking bench for xtal_ref_ctrl with a host model on its config
// assumes the package and design are compiled first
`timescale 1ns/100ps
module xtal_ref_ctrl_bench;
  logic clk = 1'b0, rst = 1'b1, ovr = 1'b0, pri = 1'b0, sec = 1'b0;
  logic plost = 1'b0, osc, spulse;
  logic [2:0] lvl = 3'h0;
  logic [15:0] code;
  logic [1:0] ppulse, onsec;
  logic [15:0][7:0] tbl;
  xtal_ref_pkg::ref_sel_s [1:0] sel = '0;
  xtal_ref_pkg::xtal_cfg_s cfg, c;
  int errors = 0, n_compared = 0, cyc = 0, n_sec = 0, n_p0 = 0, n_p1 = 0;
  xtal_host_model xtal_host_model_i (.i_clk(clk), .o_cfg(cfg));
  xtal_ref_ctrl xtal_ref_ctrl_i (
    .i_clk(clk), .i_rst(rst), .i_cfg(cfg), .i_level_trim_table(tbl),
    .i_trim_override_pin(ovr), .i_trim_level_pin(lvl), .i_primary_ref(pri),
    .i_secondary_reference_input(sec), .i_ref_sel(sel),
    .i_primary_lost(plost), .i_secondary_lost(1'b0), .o_xtal_osc_en(osc),
    .o_trim_code(code), .o_secondary_ref_pulse(spulse),
    .o_pll_ref_pulse(ppulse), .o_pll_on_secondary(onsec));
  initial forever #10 clk = ~clk;
  // ======
  // pulse tallies and hang guard
  always @(posedge clk) begin
    cyc++;
    n_sec += int'(spulse);
    n_p0 += int'(ppulse[0]);
    n_p1 += int'(ppulse[1]);
    if (cyc == 6000) begin
      errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // eight cycles outlast the slowest (level pin) path
  task automatic trim(input logic o, input logic [15:0] exp);
    ovr <= o;
    tick(8);
    cmp("trim code", exp, code);
  endtask
  // slow toggles, four clocks apart, so no edge aliases
  task automatic pulses(input bit on_sec, input int n, input int es, e0, e1);
    int s0, p0, p1;
    s0 = n_sec;
    p0 = n_p0;
    p1 = n_p1;
    repeat (n) begin
      @(posedge clk) if (on_sec) sec <= !sec; else pri <= !pri;
      tick(3);
    end
    tick(8);
    cmp("secondary pulses", 16'(es), 16'(n_sec - s0));
    cmp("pll1 pulses", 16'(e0), 16'(n_p0 - p0));
    cmp("pll2 pulses", 16'(e1), 16'(n_p1 - p1));
  endtask
  initial begin
    for (int i = 0; i < 16; i++) tbl[i] = 8'h30 + 8'(i * 7);
    c = '0;
    tick(5);
    rst <= 1'b0;
    tick(2);
    for (int k = 0; k < 8; k++) begin
      {c.secondary_type_sel_hi, c.secondary_type_sel_lo,
       c.secondary_bias_en} = 3'(k);
      xtal_host_model_i.put(c);
      tick(3);
      cmp("osc enable", 16'(k == 5), 16'(osc));
    end
    $display("crystal enable test done");
    c.trim_source_sel_lo = 1'b1;
    xtal_host_model_i.put(c);
    for (int k = 0; k < 8; k++) begin
      lvl <= 3'(k);
      trim(k[0], {tbl[2 * k], tbl[2 * k + 1]});
    end
    c.trim_source_sel_lo = 1'b0;
    xtal_host_model_i.put(c);
    lvl <= 3'h2;
    trim(1'b1, {tbl[6], tbl[7]});
    trim(1'b0, {tbl[4], tbl[5]});
    xtal_host_model_i.fixed_pair(8'hA5, 8'h3C);
    c = cfg;
    trim(1'b0, {tbl[4], tbl[5]});
    trim(1'b1, 16'hA53C);
    // select 1,1 keeps the fixed pair whatever the override pin does
    c.trim_source_sel_lo = 1'b1;
    xtal_host_model_i.put(c);
    trim(1'b0, 16'hA53C);
    $display("trim select test done");
    c.pll1_ref_divide = 3'h2;
    c.pll2_ref_divide = 3'h5;
    xtal_host_model_i.put(c);
    pulses(1'b0, 80, 0, 20, 8);
    c.pll1_ref_divide = 3'h3;
    c.pll2_ref_divide = 3'h0;
    xtal_host_model_i.put(c);
    pulses(1'b0, 80, 0, 13, 5);
    c.pll1_ref_divide = 3'h1;
    c.primary_doubler_en = 1'b1;
    xtal_host_model_i.put(c);
    // pll1 counter stands at 1, so divide-by-1 first waits for the wrap
    pulses(1'b0, 20, 0, 13, 2);
    sel[1].manual_secondary <= 1'b1;
    pulses(1'b1, 20, 10, 0, 10);
    c.secondary_doubler_en = 1'b1;
    xtal_host_model_i.put(c);
    pulses(1'b1, 20, 20, 0, 20);
    $display("reference path test done");
    // auto mode only while both references idle at one rate
    sel[0].auto_mode <= 1'b1;
    plost <= 1'b1;
    tick(3);
    cmp("on secondary", 16'h0003, 16'(onsec));
    plost <= 1'b0;
    tick(3);
    cmp("on secondary", 16'h0002, 16'(onsec));
    $display("selection test done");
    end_sim();
  end
endmodule // xtal_ref_ctrl_bench
